// ==== testbench/epm_perf_mon_bench.sv ====
// epm_perf_mon_bench: register tests of counters, monitors and loopback
// assumes epm_pkg compiled first; snapshot intervals shortened
`timescale 1ns/1ps
module epm_perf_mon_bench
  import epm_pkg::*;
;
  localparam int IV = 500;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, remote_loopback_enable_out, err;
  logic rx_bit_tgl_in = 1'b0, rx_bit_val_in = 1'b0, tx_bit_tgl_in = 1'b0, tx_bit_val_in = 1'b0;
  logic [4:0] rx_slot_in = 5'h0, tx_slot_in = 5'h0;
  logic [2:0] rx_bit_pos_in = 3'h0, tx_bit_pos_in = 3'h0;
  logic [3:0] rx_frame_in = 4'h0;
  logic crc_err_tgl_in = 1'b0, fas_err_tgl_in = 1'b0, crc4_mode_in = 1'b1;
  logic fas_sync_loss_in = 1'b0, crc4_sync_loss_in = 1'b0, receive_sync_loss_flag_in = 1'b0;
  logic fas_hunt_in = 1'b0, cas_hunt_in = 1'b0, crc4_hunt_in = 1'b0;
  logic [7:0] rd;
  int fails = 0, samples_checked = 0, cyc = 0, t0 = 0;
  epm_perf_mon #(.SHORT_CYC(IV), .LONG_CYC(1000)) u_dut (.*);
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 20) fails++;
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  // one line bit: inputs settle, then the toggle, then a quiet gap
  task automatic lbit(input logic rx, input logic [4:0] s, input logic [2:0] p,
      input logic [3:0] f, input logic v);
    if (rx) begin
      rx_slot_in <= s;
      rx_bit_pos_in <= p;
      rx_frame_in <= f;
      rx_bit_val_in <= v;
    end else begin
      tx_slot_in <= s;
      tx_bit_pos_in <= p;
      tx_bit_val_in <= v;
    end
    repeat (7) @(posedge sys_clk_in);
    if (rx) rx_bit_tgl_in <= !rx_bit_tgl_in;
    else tx_bit_tgl_in <= !tx_bit_tgl_in;
    repeat (7) @(posedge sys_clk_in);
  endtask
  task automatic lbyte(input logic rx, input logic [4:0] s, input logic [7:0] b,
      input int lo, input int hi);
    for (int i = lo; i < hi; i++) lbit(rx, s, 3'(i), 4'h0, b[7 - i]);
  endtask
  task automatic terr(input logic crc);
    if (crc) crc_err_tgl_in <= !crc_err_tgl_in;
    else fas_err_tgl_in <= !fas_err_tgl_in;
    repeat (8) @(posedge sys_clk_in);
  endtask
  // snapshot boundaries are periodic, so a phase counter replaces polling
  task automatic phase();
    do @(posedge sys_clk_in); while ((cyc - t0) % IV != 10);
  endtask
  task automatic iv_run(input string nm, input logic [11:0] f, input logic [9:0] c,
      input logic [9:0] e);
    phase();
    repeat (3) terr(1'b0);
    repeat (2) terr(1'b1);
    lbit(1'b1, 5'h00, 3'h0, 4'hd, 1'b0);
    lbit(1'b1, 5'h00, 3'h0, 4'hf, 1'b0);
    lbit(1'b1, 5'h00, 3'h0, 4'hf, 1'b1);
    lbit(1'b1, 5'h00, 3'h0, 4'hc, 1'b0);
    lbit(1'b1, 5'h00, 3'h1, 4'hd, 1'b0);
    phase();
    rdc(EPM_CRC_FAS_COUNT_HIGH_ADDR, {f[11:6], c[9:8]});
    rdc(EPM_CRC_COUNT_LOW_ADDR, c[7:0]);
    rdc(EPM_FAS_EBIT_COUNT_MID_ADDR, {f[5:0], e[9:8]});
    rdc(EPM_EBIT_COUNT_LOW_ADDR, e[7:0]);
    $display("test %s done", nm);
  endtask
  // ****************************************
  // sequence of tests
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rdc(EPM_LOOPBACK_TX_MON_SEL_ADDR, 8'h00);
    // software keeps the unassigned bits 6:5 at zero
    apb(1'b1, EPM_LOOPBACK_TX_MON_SEL_ADDR, 8'h9f);
    rdc(EPM_LOOPBACK_TX_MON_SEL_ADDR, 8'h9f);
    chk("loopback on", 8'h01, {7'h0, remote_loopback_enable_out});
    apb(1'b1, EPM_LOOPBACK_TX_MON_SEL_ADDR, 8'h05);
    chk("loopback off", 8'h00, {7'h0, remote_loopback_enable_out});
    apb(1'b1, EPM_RX_MON_SEL_ADDR, 8'h0e);
    rdc(EPM_RX_MON_SEL_ADDR, 8'h0e);
    rdc(8'h06, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, err});
    $display("test registers done");
    lbyte(1'b0, 5'h04, 8'hff, 0, 8);
    lbyte(1'b0, 5'h05, 8'ha5, 0, 8);
    lbyte(1'b0, 5'h06, 8'h00, 0, 8);
    lbyte(1'b1, 5'h0d, 8'h00, 0, 8);
    lbyte(1'b1, 5'h0e, 8'h3c, 0, 8);
    lbyte(1'b1, 5'h0f, 8'hff, 0, 8);
    rdc(EPM_TX_MON_BYTE_ADDR, 8'ha5);
    rdc(EPM_RX_MON_BYTE_ADDR, 8'h3c);
    lbyte(1'b0, 5'h05, 8'h5a, 0, 4);
    rdc(EPM_TX_MON_BYTE_ADDR, 8'ha5);
    lbyte(1'b0, 5'h05, 8'h5a, 4, 8);
    rdc(EPM_TX_MON_BYTE_ADDR, 8'h5a);
    $display("test monitors done");
    apb(1'b1, EPM_INTERVAL_CTRL_ADDR, 8'h80);
    terr(1'b0);
    rd = 8'h00;
    for (int i = 0; i < 400 && rd == 8'h00; i++) apb(1'b0, EPM_FAS_EBIT_COUNT_MID_ADDR, 8'h00);
    t0 = cyc;
    chk("first snapshot", 8'h04, rd);
    iv_run("counting", 12'h003, 10'h002, 10'h002);
    cas_hunt_in <= 1'b1;
    iv_run("cas hunt", 12'h000, 10'h002, 10'h002);
    cas_hunt_in <= 1'b0;
    receive_sync_loss_flag_in <= 1'b1;
    crc4_sync_loss_in <= 1'b1;
    iv_run("sync loss", 12'h000, 10'h000, 10'h000);
    results();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fails++;
    results();
  end
endmodule // epm_perf_mon_bench

// ==== testbench/epm_perf_mon_properties.sv ====
// epm_perf_mon_properties: apb and loopback checks on the top ports
// assumes epm_pkg compiled first; bound into every epm_perf_mon
`timescale 1ns/1ps
module epm_perf_mon_properties
  import epm_pkg::*;
#(
  parameter int SHORT_CYC = 40,
  parameter int LONG_CYC = 100
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic remote_loopback_enable_out
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic mapped = paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00 &&
    paddr[9:2] inside {EPM_CRC_FAS_COUNT_HIGH_ADDR, EPM_CRC_COUNT_LOW_ADDR,
    EPM_FAS_EBIT_COUNT_MID_ADDR, EPM_EBIT_COUNT_LOW_ADDR, EPM_LOOPBACK_TX_MON_SEL_ADDR,
    EPM_TX_MON_BYTE_ADDR, EPM_RX_MON_SEL_ADDR, EPM_RX_MON_BYTE_ADDR, EPM_INTERVAL_CTRL_ADDR};
  wire logic sel_hit = paddr == {22'h0, EPM_LOOPBACK_TX_MON_SEL_ADDR, 2'b00};
  sequence access_s;
    psel && penable;
  endsequence
  sequence rd_setup_s;
    psel && !penable && !pwrite;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  loopback_write_a: assert property (access_s ##0 pwrite && sel_hit |=>
    remote_loopback_enable_out == $past(pwdata[7])) else $error("loopback not written");
  loopback_hold_a: assert property (!(psel && penable && pwrite) |=>
    $stable(remote_loopback_enable_out)) else $error("loopback changed without write");
  sel_readback_a: assert property (rd_setup_s ##0 sel_hit ##1 access_s |->
    prdata[6:5] == 2'b00 && prdata[7] == remote_loopback_enable_out)
    else $error("select byte readback wrong");
  upper_zero_a: assert property (access_s |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  mapped_ok_a: assert property (access_s ##0 mapped |-> pready && !pslverr)
    else $error("mapped access refused");
  unmapped_err_a: assert property (access_s ##0 !mapped |-> pready && pslverr)
    else $error("unmapped access not refused");
  unmapped_zero_a: assert property (rd_setup_s ##0 !mapped ##1 access_s |-> prdata == 0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
endmodule // epm_perf_mon_properties

bind epm_perf_mon epm_perf_mon_properties #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_props (.*);

// ==== verilog/epm_chan_mon.sv ====
// epm_chan_mon: captures the selected timeslot byte of one direction
// assumes bit strobes already synchronised to sys_clk_in
`timescale 1ns/1ps
module epm_chan_mon
  import epm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  epm_mon_if.mon mon_if
);
  // ****************************************
  // shift and capture
  // ****************************************
  epm_byte_t shift_r;
  epm_byte_t hold_r;
  logic hit;
  assign hit = mon_if.bit_stb && (mon_if.slot == mon_if.sel);
  // first line bit ends in bit 7
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      shift_r <= 8'h00;
    end else if (hit) begin
      shift_r <= {shift_r[6:0], mon_if.bit_val};
    end
  end
  // update only after the whole slot, so software never sees a split byte
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hold_r <= 8'h00;
    end else if (hit && mon_if.bit_pos == EPM_LAST_BIT) begin
      hold_r <= {shift_r[6:0], mon_if.bit_val};
    end
  end
  assign mon_if.mon_byte = hold_r;
endmodule // epm_chan_mon

// ==== verilog/epm_mon_if.sv ====
// epm_mon_if: bundle carrying one direction of line data into a channel monitor
// assumes all signals are synchronous to sys_clk_in
`timescale 1ns/1ps
interface epm_mon_if;
  logic bit_stb;
  logic bit_val;
  logic [4:0] slot;
  logic [2:0] bit_pos;
  logic [4:0] sel;
  logic [7:0] mon_byte;
  modport src (output bit_stb, output bit_val, output slot, output bit_pos, output sel,
    input mon_byte);
  modport mon (input bit_stb, input bit_val, input slot, input bit_pos, input sel,
    output mon_byte);
endinterface // epm_mon_if

// ==== verilog/epm_perf_mon.sv ====
// epm_perf_mon: e1 error counters, channel monitors and loopback control
// assumes line strobes arrive from another domain as slow levels/toggles,
// and an APB master on sys_clk_in
//
// Summary of operation
// - byte 02: align bits 11:6, crc 9:8
// - align error counter twelve bits wide
// - byte 04: align bits 5:0, ebit 9:8
// - ebit counter sees frames 13,15 only
// - count one per zero e-bit
// - ebit held on frame/crc4 sync loss
// - count each bad alignment word
// - no align count during sync loss
// - no align count while hunting alignment
// - tx and rx monitors run concurrently
// - tx select bits 4:0 at a8
// - copy selected slot into monitor byte
// - select value equals channel minus one
// - bit 7 at a8 enables loopback
// - snapshot counts each second or 62.5ms
// - counters saturate, never wrap
// - crc counter held on frame/crc4 loss
// - bit 7 is first line bit
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module epm_perf_mon
  import epm_pkg::*;
#(
  parameter int SHORT_CYC = EPM_SHORT_CYC,
  parameter int LONG_CYC = EPM_LONG_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_tgl_in,
  input wire logic rx_bit_val_in,
  input wire logic [4:0] rx_slot_in,
  input wire logic [2:0] rx_bit_pos_in,
  input wire logic [3:0] rx_frame_in,
  input wire logic tx_bit_tgl_in,
  input wire logic tx_bit_val_in,
  input wire logic [4:0] tx_slot_in,
  input wire logic [2:0] tx_bit_pos_in,
  input wire logic crc_err_tgl_in,
  input wire logic fas_err_tgl_in,
  input wire logic crc4_mode_in,
  input wire logic fas_sync_loss_in,
  input wire logic crc4_sync_loss_in,
  input wire logic receive_sync_loss_flag_in,
  input wire logic fas_hunt_in,
  input wire logic cas_hunt_in,
  input wire logic crc4_hunt_in,
  output logic remote_loopback_enable_out
);
  // ****************************************
  // pin synchronisers (3 stages, 2nd and 3rd must agree)
  // ****************************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] clean_r;
  assign raw = {rx_bit_tgl_in, tx_bit_tgl_in, crc_err_tgl_in, fas_err_tgl_in, fas_sync_loss_in,
    crc4_sync_loss_in, receive_sync_loss_flag_in, fas_hunt_in | cas_hunt_in, crc4_hunt_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          clean_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            clean_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  // bit values and positions are stable around their toggle, so they are
  // registered once here, sampled alongside the toggle's settling
  logic rx_val_r;
  logic tx_val_r;
  logic [4:0] rx_slot_r;
  logic [4:0] tx_slot_r;
  logic [2:0] rx_pos_r;
  logic [2:0] tx_pos_r;
  logic [3:0] rx_frame_r;
  logic [NSYNC-1:0] prev_r;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_val_r <= 1'b0;
      tx_val_r <= 1'b0;
      rx_slot_r <= 5'h00;
      tx_slot_r <= 5'h00;
      rx_pos_r <= 3'h0;
      tx_pos_r <= 3'h0;
      rx_frame_r <= 4'h0;
      prev_r <= '0;
    end else begin
      rx_val_r <= rx_bit_val_in;
      tx_val_r <= tx_bit_val_in;
      rx_slot_r <= rx_slot_in;
      tx_slot_r <= tx_slot_in;
      rx_pos_r <= rx_bit_pos_in;
      tx_pos_r <= tx_bit_pos_in;
      rx_frame_r <= rx_frame_in;
      prev_r <= clean_r;
    end
  end
  logic rx_stb;
  logic tx_stb;
  logic crc_stb;
  logic fas_stb;
  logic fas_loss;
  logic crc4_loss;
  logic sync_loss;
  logic align_hunt;
  logic crc4_hunt;
  assign rx_stb = clean_r[8] ^ prev_r[8];
  assign tx_stb = clean_r[7] ^ prev_r[7];
  assign crc_stb = clean_r[6] ^ prev_r[6];
  assign fas_stb = clean_r[5] ^ prev_r[5];
  assign fas_loss = clean_r[4];
  assign crc4_loss = clean_r[3];
  assign sync_loss = clean_r[2];
  assign align_hunt = clean_r[1];
  assign crc4_hunt = clean_r[0];
  // ****************************************
  // control registers
  // ****************************************
  epm_byte_t tx_sel_ctrl_r;
  epm_byte_t rx_sel_ctrl_r;
  epm_byte_t interval_ctrl_r;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  // odd printed offsets, so each register is one aligned word at index * 4
  assign addr = paddr[9:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_sel_ctrl_r <= EPM_SEL_RESET;
      rx_sel_ctrl_r <= EPM_SEL_RESET;
      interval_ctrl_r <= EPM_SEL_RESET;
    end else if (wr_en && paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00) begin
      // bits 6:5 are kept at zero whatever software writes
      if (addr == EPM_LOOPBACK_TX_MON_SEL_ADDR) begin
        tx_sel_ctrl_r <= pwdata[7:0] & EPM_CTRL_WR_MASK;
      end
      if (addr == EPM_RX_MON_SEL_ADDR) begin
        rx_sel_ctrl_r <= {3'h0, pwdata[4:0]};
      end
      if (addr == EPM_INTERVAL_CTRL_ADDR) begin
        interval_ctrl_r <= {pwdata[7], 7'h00};
      end
    end
  end
  assign remote_loopback_enable_out = tx_sel_ctrl_r[EPM_LOOPBACK_BIT];
  // ****************************************
  // snapshot interval timer
  // ****************************************
  logic [24:0] tick_cnt_r;
  logic [24:0] tick_lim;
  logic snap;
  assign tick_lim = interval_ctrl_r[EPM_INTERVAL_BIT] ? 25'(SHORT_CYC - 1) : 25'(LONG_CYC - 1);
  assign snap = (tick_cnt_r >= tick_lim);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_r <= 25'h0000000;
    end else if (snap) begin
      tick_cnt_r <= 25'h0000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 25'h0000001;
    end
  end
  // ****************************************
  // error counters
  // ****************************************
  function automatic logic [11:0] sat_inc(input logic [11:0] v, input logic [11:0] max,
    input logic inc);
    sat_inc = (inc && v != max) ? v + 12'h001 : v;
  endfunction
  logic crc_inc;
  logic ebit_inc;
  logic fas_inc;
  logic ebit_slot;
  assign crc_inc = crc_stb && !fas_loss && !crc4_loss;
  assign ebit_slot = rx_stb && crc4_mode_in && rx_slot_r == 5'h00 && rx_pos_r == 3'h0 &&
    (rx_frame_r == EPM_EBIT_FRAME_A || rx_frame_r == EPM_EBIT_FRAME_B);
  assign ebit_inc = ebit_slot && !rx_val_r && !fas_loss && !crc4_loss;
  assign fas_inc = fas_stb && !sync_loss &&
    !align_hunt && !crc4_hunt;
  logic [EPM_CRC_W-1:0] crc_acc_r;
  logic [EPM_EBIT_W-1:0] ebit_acc_r;
  logic [EPM_FAS_W-1:0] fas_acc_r;
  logic [EPM_CRC_W-1:0] crc_cnt_r;
  logic [EPM_EBIT_W-1:0] ebit_cnt_r;
  logic [EPM_FAS_W-1:0] fas_cnt_r;
  // an event landing on the snapshot edge starts the new interval
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      crc_acc_r <= '0;
      ebit_acc_r <= '0;
      fas_acc_r <= '0;
    end else if (snap) begin
      crc_acc_r <= {{(EPM_CRC_W-1){1'b0}}, crc_inc};
      ebit_acc_r <= {{(EPM_EBIT_W-1){1'b0}}, ebit_inc};
      fas_acc_r <= {{(EPM_FAS_W-1){1'b0}}, fas_inc};
    end else begin
      crc_acc_r <= EPM_CRC_W'(sat_inc({2'b00, crc_acc_r}, 12'h3ff, crc_inc));
      ebit_acc_r <= EPM_EBIT_W'(sat_inc({2'b00, ebit_acc_r}, 12'h3ff, ebit_inc));
      fas_acc_r <= sat_inc(fas_acc_r, 12'hfff, fas_inc);
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      crc_cnt_r <= '0;
      ebit_cnt_r <= '0;
      fas_cnt_r <= '0;
    end else if (snap) begin
      crc_cnt_r <= crc_acc_r;
      ebit_cnt_r <= ebit_acc_r;
      fas_cnt_r <= fas_acc_r;
    end
  end
  // ****************************************
  // channel monitors
  // ****************************************
  epm_mon_if tx_if ();
  epm_mon_if rx_if ();
  // select value is the timeslot number, i.e. channel minus one
  assign tx_if.bit_stb = tx_stb;
  assign tx_if.bit_val = tx_val_r;
  assign tx_if.slot = tx_slot_r;
  assign tx_if.bit_pos = tx_pos_r;
  assign tx_if.sel = tx_sel_ctrl_r[EPM_CH_W-1:0];
  assign rx_if.bit_stb = rx_stb;
  assign rx_if.bit_val = rx_val_r;
  assign rx_if.slot = rx_slot_r;
  assign rx_if.bit_pos = rx_pos_r;
  assign rx_if.sel = rx_sel_ctrl_r[EPM_CH_W-1:0];
  epm_chan_mon u_tx_mon (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .mon_if(tx_if)
  );
  epm_chan_mon u_rx_mon (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .mon_if(rx_if)
  );
  // ****************************************
  // apb read path
  // ****************************************
  epm_byte_t rd_byte;
  logic hit;
  always_comb begin
    rd_byte = 8'h00;
    hit = 1'b1;
    unique case (addr)
      EPM_CRC_FAS_COUNT_HIGH_ADDR: rd_byte = {fas_cnt_r[11:6], crc_cnt_r[9:8]};
      EPM_CRC_COUNT_LOW_ADDR: rd_byte = crc_cnt_r[7:0];
      EPM_FAS_EBIT_COUNT_MID_ADDR: rd_byte = {fas_cnt_r[5:0], ebit_cnt_r[9:8]};
      EPM_EBIT_COUNT_LOW_ADDR: rd_byte = ebit_cnt_r[7:0];
      EPM_LOOPBACK_TX_MON_SEL_ADDR: rd_byte = tx_sel_ctrl_r;
      EPM_TX_MON_BYTE_ADDR: rd_byte = tx_if.mon_byte;
      EPM_RX_MON_SEL_ADDR: rd_byte = rx_sel_ctrl_r;
      EPM_RX_MON_BYTE_ADDR: rd_byte = rx_if.mon_byte;
      EPM_INTERVAL_CTRL_ADDR: rd_byte = interval_ctrl_r;
      default: hit = 1'b0;
    endcase
    if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end
  // zero wait states: ready is high in every access phase
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end else if (rd_en && !hit) begin
      prdata <= 32'h00000000;
    end
  end
endmodule // epm_perf_mon

// ==== verilog/epm_pkg.sv ====
// epm_pkg: constants for the e1 performance counter and channel monitor block
// assumes a 25 MHz system clock and an APB register port
package epm_pkg;
  // ****************************************
  // register indices; the byte address is four times the index
  // ****************************************
  localparam logic [7:0] EPM_CRC_FAS_COUNT_HIGH_ADDR = 8'h02;
  localparam logic [7:0] EPM_CRC_COUNT_LOW_ADDR = 8'h03;
  localparam logic [7:0] EPM_FAS_EBIT_COUNT_MID_ADDR = 8'h04;
  localparam logic [7:0] EPM_EBIT_COUNT_LOW_ADDR = 8'h05;
  localparam logic [7:0] EPM_LOOPBACK_TX_MON_SEL_ADDR = 8'ha8;
  localparam logic [7:0] EPM_TX_MON_BYTE_ADDR = 8'ha9;
  localparam logic [7:0] EPM_RX_MON_SEL_ADDR = 8'haa;
  localparam logic [7:0] EPM_RX_MON_BYTE_ADDR = 8'hac;
  localparam logic [7:0] EPM_INTERVAL_CTRL_ADDR = 8'hb0;
  // ****************************************
  // field layout
  // ****************************************
  localparam int EPM_CRC_W = 10;
  localparam int EPM_EBIT_W = 10;
  localparam int EPM_FAS_W = 12;
  localparam int EPM_CH_W = 5;
  localparam int EPM_LOOPBACK_BIT = 7;
  localparam int EPM_INTERVAL_BIT = 7;
  localparam logic [7:0] EPM_SEL_RESET = 8'h00;
  localparam logic [7:0] EPM_CTRL_WR_MASK = 8'h9f;
  // ****************************************
  // frame and multiframe positions
  // ****************************************
  localparam logic [3:0] EPM_EBIT_FRAME_A = 4'hd;
  localparam logic [3:0] EPM_EBIT_FRAME_B = 4'hf;
  localparam logic [2:0] EPM_LAST_BIT = 3'h7;
  // ****************************************
  // timing
  // ****************************************
  localparam int EPM_CLK_HZ = 25000000;
  localparam int EPM_SHORT_INTERVAL_US = 62500;
  localparam int EPM_LONG_INTERVAL_US = 1000000;
  localparam int EPM_SHORT_CYC = (EPM_CLK_HZ / 1000) * EPM_SHORT_INTERVAL_US / 1000;
  localparam int EPM_LONG_CYC = (EPM_CLK_HZ / 1000) * (EPM_LONG_INTERVAL_US / 1000);
  typedef logic [7:0] epm_byte_t;
endpackage
